// ==== src/tcc_pkg.sv ====
// Constants for the capture/compare timer: offsets, fields, resets.
// Assumes an 8-bit register port with a 4-bit address.
package tcc_pkg;
   // Register offsets
   localparam logic [3:0] TCC_A_CNT_HI = 4'h0;
   localparam logic [3:0] TCC_A_CNT_LO = 4'h1;
   localparam logic [3:0] TCC_A_RLD_HI = 4'h2;
   localparam logic [3:0] TCC_A_RLD_LO = 4'h3;
   localparam logic [3:0] TCC_A_CTL0 = 4'h4;
   localparam logic [3:0] TCC_A_CTL1 = 4'h5;
   localparam logic [3:0] TCC_A_CAP_HI = 4'h6;
   localparam logic [3:0] TCC_A_CAP_LO = 4'h7;
   localparam logic [3:0] TCC_A_STS = 4'h8;
   localparam logic [3:0] TCC_A_MSK = 4'h9;
   // Field positions
   localparam int TCC_B_ALT = 7;
   localparam int TCC_B_EN = 7;
   localparam int TCC_B_POL = 6;
   localparam int TCC_B_CAP = 0;
   localparam int TCC_B_RLD = 1;
   // Interrupt source select codes, timer_control_first[1:0]
   localparam logic [1:0] TCC_SEL_BOTH = 2'h0;
   localparam logic [1:0] TCC_SEL_CAP = 2'h1;
   localparam logic [1:0] TCC_SEL_RLD = 2'h2;
   // Reset values
   localparam logic [15:0] TCC_RST_CNT = 16'h0001;
   localparam logic [15:0] TCC_RST_RLD = 16'hffff;
   localparam logic [7:0] TCC_RST_CTL = 8'h00;
   localparam logic [1:0] TCC_RST_IRQ = 2'h0;
   localparam logic [6:0] TCC_RST_DIV = 7'h00;
   typedef enum logic [0:0] {
      TCC_IDLE = 1'b0,
      TCC_RUN = 1'b1
   } tcc_run_t;
endpackage

// ==== src/tcc_edge_sync.sv ====
// Two-flop synchroniser of the timer input with edge pulses.
// Assumes tin is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module tcc_edge_sync
   import tcc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic tin,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } tcc_sync_t;
   tcc_sync_t r_ff, nxt_r;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.s1 = tin;
      nxt_r.s2 = r_ff.s1;
      nxt_r.s3 = r_ff.s2;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Edges seen only after the second flop
   assign rise = r_ff.s2 & ~r_ff.s3;
   assign fall = ~r_ff.s2 & r_ff.s3;
endmodule
`default_nettype wire

// ==== src/tcc_prescale.sv ====
// Prescaler: one-cycle tick every 2**sel clocks while run is high.
// Assumes run and sel come from logic on clk.
`timescale 1ns/10ps
`default_nettype none
module tcc_prescale
   import tcc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   typedef struct packed {
      logic [6:0] div;
   } tcc_div_t;
   tcc_div_t r_ff, nxt_r;
   logic [6:0] limit;

   assign limit = 7'((8'h01 << sel) - 8'h01);
   assign tick = run && (r_ff.div == limit);

   always_comb begin
      nxt_r = r_ff;
      if (!run || tick) begin
         nxt_r.div = TCC_RST_DIV;
      end else begin
         nxt_r.div = r_ff.div + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_ff <= '{div: TCC_RST_DIV};
      end else begin
         r_ff <= nxt_r;
      end
   end
endmodule
`default_nettype wire

// ==== src/tcc_timer.sv ====
// 16-bit capture/compare timer with coherent count readout.
// Assumes one-cycle rd/wr strobes on clk; tin is an asynchronous pin.
`timescale 1ns/10ps
`default_nettype none
module tcc_timer
   import tcc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic tin,
   output logic tmr_out,
   output logic tmr_out_oe,
   output logic irq
);
   typedef struct packed {
      tcc_run_t run;
      logic [15:0] cnt;
      logic [15:0] start;
      logic [15:0] rld;
      logic [15:0] cap;
      logic [7:0] hold;
      logic [7:0] ctl0;
      logic [7:0] ctl1;
      logic [1:0] sts;
      logic [1:0] msk;
      logic tout;
      logic pin;
      logic [7:0] rdata;
   } tcc_state_t;

   tcc_state_t r_ff, nxt_r;
   logic rise, fall, tick, en, running, edge_sel;
   logic cap_evt, rld_evt;
   logic [1:0] set_sts;

   function automatic logic hit(input logic [3:0] a,
                                input logic [3:0] off);
      return a == off;
   endfunction

   tcc_edge_sync u_sync (
      .clk (clk),
      .rstn (rstn),
      .tin (tin),
      .rise (rise),
      .fall (fall)
   );

   assign en = r_ff.ctl1[TCC_B_EN];
   assign running = en && (r_ff.run == TCC_RUN);

   tcc_prescale u_pre (
      .clk (clk),
      .rstn (rstn),
      .run (running),
      .sel (r_ff.ctl1[2:0]),
      .tick (tick)
   );

   // Selected input edge
   assign edge_sel = r_ff.ctl1[TCC_B_POL] ? rise : fall;

   always_comb begin
      nxt_r = r_ff;
      cap_evt = 1'b0;
      rld_evt = 1'b0;
      set_sts = 2'h0;
      nxt_r.rdata = 8'h00;
      unique case (r_ff.run)
         TCC_IDLE: begin
            // First edge only starts counting
            if (en && edge_sel) begin
               nxt_r.run = TCC_RUN;
            end
         end
         TCC_RUN: begin
            if (!en) begin
               nxt_r.run = TCC_IDLE;
            end else begin
               if (edge_sel) begin
                  cap_evt = 1'b1;
                  nxt_r.cap = r_ff.cnt;
               end
               if (tick) begin
                  if (r_ff.cnt == r_ff.rld) begin
                     rld_evt = 1'b1;
                     nxt_r.cnt = r_ff.start;
                     nxt_r.tout = ~r_ff.tout;
                  end else begin
                     nxt_r.cnt = r_ff.cnt + 16'h0001;
                  end
               end
            end
         end
      endcase
      // Interrupt source gating
      if (r_ff.ctl0[1:0] != TCC_SEL_RLD) begin
         set_sts[TCC_B_CAP] = cap_evt;
      end
      if (r_ff.ctl0[1:0] != TCC_SEL_CAP) begin
         set_sts[TCC_B_RLD] = rld_evt;
      end
      // Register writes
      if (wr) begin
         if (hit(addr, TCC_A_CNT_HI)) begin
            nxt_r.cnt[15:8] = wdata;
            nxt_r.start[15:8] = wdata;
         end
         if (hit(addr, TCC_A_CNT_LO)) begin
            nxt_r.cnt[7:0] = wdata;
            nxt_r.start[7:0] = wdata;
         end
         if (hit(addr, TCC_A_RLD_HI)) begin
            nxt_r.rld[15:8] = wdata;
         end
         if (hit(addr, TCC_A_RLD_LO)) begin
            nxt_r.rld[7:0] = wdata;
         end
         if (hit(addr, TCC_A_CTL0)) begin
            nxt_r.ctl0 = wdata;
         end
         if (hit(addr, TCC_A_CTL1)) begin
            nxt_r.ctl1 = wdata;
         end
         if (hit(addr, TCC_A_MSK)) begin
            nxt_r.msk = wdata[1:0];
         end
      end
      // Sticky status, set wins over write-one clear
      if (wr && hit(addr, TCC_A_STS)) begin
         nxt_r.sts = (r_ff.sts & ~wdata[1:0]) | set_sts;
      end else begin
         nxt_r.sts = r_ff.sts | set_sts;
      end
      // Register reads, data in the next cycle
      if (rd) begin
         if (hit(addr, TCC_A_CNT_HI)) begin
            nxt_r.rdata = r_ff.cnt[15:8];
            if (en) begin
               nxt_r.hold = r_ff.cnt[7:0];
            end
         end
         if (hit(addr, TCC_A_CNT_LO)) begin
            // Held byte while enabled, live byte otherwise
            nxt_r.rdata = en ? r_ff.hold : r_ff.cnt[7:0];
         end
         if (hit(addr, TCC_A_RLD_HI)) begin
            nxt_r.rdata = r_ff.rld[15:8];
         end
         if (hit(addr, TCC_A_RLD_LO)) begin
            nxt_r.rdata = r_ff.rld[7:0];
         end
         if (hit(addr, TCC_A_CTL0)) begin
            nxt_r.rdata = r_ff.ctl0;
         end
         if (hit(addr, TCC_A_CTL1)) begin
            nxt_r.rdata = r_ff.ctl1;
         end
         if (hit(addr, TCC_A_CAP_HI)) begin
            nxt_r.rdata = r_ff.cap[15:8];
         end
         if (hit(addr, TCC_A_CAP_LO)) begin
            nxt_r.rdata = r_ff.cap[7:0];
         end
         if (hit(addr, TCC_A_STS)) begin
            nxt_r.rdata = {6'h00, r_ff.sts};
         end
         if (hit(addr, TCC_A_MSK)) begin
            nxt_r.rdata = {6'h00, r_ff.msk};
         end
      end
      // Pin driven only under the alternate function
      nxt_r.pin = r_ff.ctl0[TCC_B_ALT] & r_ff.tout;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_ff <= '{run: TCC_IDLE, cnt: TCC_RST_CNT, start: TCC_RST_CNT,
                   rld: TCC_RST_RLD, cap: 16'h0000, hold: 8'h00,
                   ctl0: TCC_RST_CTL, ctl1: TCC_RST_CTL,
                   sts: TCC_RST_IRQ, msk: TCC_RST_IRQ, tout: 1'b0,
                   pin: 1'b0, rdata: 8'h00};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign rdata = r_ff.rdata;
   assign tmr_out = r_ff.pin;
   assign tmr_out_oe = r_ff.ctl0[TCC_B_ALT];
   assign irq = |(r_ff.sts & r_ff.msk);

   // Checks

   a_wait_no_count: assert property (
      @(posedge clk) disable iff (!rstn)
      (r_ff.run == TCC_IDLE && !wr) |=> $stable(r_ff.cnt))
      else $error("counter moved before first edge");

   a_first_edge_quiet: assert property (
      @(posedge clk) disable iff (!rstn)
      (r_ff.run == TCC_IDLE && en && edge_sel && !wr)
      |=> ($stable(r_ff.cap) && r_ff.sts[TCC_B_CAP] ==
           $past(r_ff.sts[TCC_B_CAP])))
      else $error("start edge treated as capture");

   a_tick_count: assert property (
      @(posedge clk) disable iff (!rstn)
      (running && tick && r_ff.cnt != r_ff.rld && !wr)
      |=> r_ff.cnt == $past(r_ff.cnt) + 16'h0001)
      else $error("counter did not advance on tick");

   a_no_tick_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      (running && !tick && !wr) |=> $stable(r_ff.cnt))
      else $error("counter moved without tick");

   a_reload_start: assert property (
      @(posedge clk) disable iff (!rstn)
      (running && tick && r_ff.cnt == r_ff.rld && !wr)
      |=> (r_ff.cnt == $past(r_ff.start) && r_ff.tout != $past(r_ff.tout)))
      else $error("compare match did not reload");

   a_out_toggle: assert property (
      @(posedge clk) disable iff (!rstn)
      !rld_evt |=> $stable(r_ff.tout))
      else $error("output toggled without reload");

   a_cap_store: assert property (
      @(posedge clk) disable iff (!rstn)
      cap_evt |=> r_ff.cap == $past(r_ff.cnt))
      else $error("capture value not stored");

   a_hold_latch: assert property (
      @(posedge clk) disable iff (!rstn)
      (rd && addr == TCC_A_CNT_HI && en)
      |=> r_ff.hold == $past(r_ff.cnt[7:0]))
      else $error("low byte not held on high read");

   a_lo_read: assert property (
      @(posedge clk) disable iff (!rstn)
      (rd && addr == TCC_A_CNT_LO)
      |=> rdata == (($past(en)) ? $past(r_ff.hold) : $past(r_ff.cnt[7:0])))
      else $error("low byte read wrong source");

   a_cap_irq: assert property (
      @(posedge clk) disable iff (!rstn)
      (cap_evt && r_ff.ctl0[1:0] == TCC_SEL_BOTH && r_ff.msk[TCC_B_CAP]
       && !wr) |=> irq)
      else $error("capture did not raise interrupt");

   a_sel_cap_only: assert property (
      @(posedge clk) disable iff (!rstn)
      (rld_evt && r_ff.ctl0[1:0] == TCC_SEL_CAP && !r_ff.sts[TCC_B_RLD])
      |=> !r_ff.sts[TCC_B_RLD])
      else $error("reload flagged in capture-only mode");

   a_pin_gate: assert property (
      @(posedge clk) disable iff (!rstn)
      !r_ff.ctl0[TCC_B_ALT] |=> !tmr_out)
      else $error("pin driven without alternate function");

   a_pin_follow: assert property (
      @(posedge clk) disable iff (!rstn)
      r_ff.ctl0[TCC_B_ALT] |=> tmr_out == $past(r_ff.tout))
      else $error("pin does not follow output level");

   a_sts_set_wins: assert property (
      @(posedge clk) disable iff (!rstn)
      (set_sts != 2'h0)
      |=> ((r_ff.sts & $past(set_sts)) == $past(set_sts)))
      else $error("status event lost to clear");

   a_rld_irq: assert property (
      @(posedge clk) disable iff (!rstn)
      (rld_evt && r_ff.ctl0[1:0] == TCC_SEL_BOTH && r_ff.msk[TCC_B_RLD]
       && !wr) |=> irq)
      else $error("reload did not raise interrupt");

   a_sel_rld_only: assert property (
      @(posedge clk) disable iff (!rstn)
      (cap_evt && r_ff.ctl0[1:0] == TCC_SEL_RLD && !r_ff.sts[TCC_B_CAP])
      |=> !r_ff.sts[TCC_B_CAP])
      else $error("capture flagged in reload-only mode");

   a_edge_start: assert property (
      @(posedge clk) disable iff (!rstn)
      (r_ff.run == TCC_IDLE && en && edge_sel) |=> r_ff.run == TCC_RUN)
      else $error("selected edge did not start counting");

   a_disable_idle: assert property (
      @(posedge clk) disable iff (!rstn)
      !en |=> r_ff.run == TCC_IDLE)
      else $error("disabled timer left running");

   a_disabled_quiet: assert property (
      @(posedge clk) disable iff (!rstn)
      !en |-> (!cap_evt && !rld_evt))
      else $error("event while timer disabled");

   a_tick_spacing: assert property (
      @(posedge clk) disable iff (!rstn)
      (tick && r_ff.ctl1[2:0] != 3'h0 && !wr) |=> !tick)
      else $error("prescaler ticked twice in a row");

   a_reload_on_tick: assert property (
      @(posedge clk) disable iff (!rstn)
      rld_evt |-> (tick && r_ff.cnt == r_ff.rld))
      else $error("reload without tick and match");

   a_cap_keep: assert property (
      @(posedge clk) disable iff (!rstn)
      !cap_evt |=> $stable(r_ff.cap))
      else $error("capture register changed without capture");

   a_hi_read: assert property (
      @(posedge clk) disable iff (!rstn)
      (rd && addr == TCC_A_CNT_HI) |=> rdata == $past(r_ff.cnt[15:8]))
      else $error("high byte read wrong value");

   a_lo_live: assert property (
      @(posedge clk) disable iff (!rstn)
      (rd && addr == TCC_A_CNT_LO && !en) |=> rdata == $past(r_ff.cnt[7:0]))
      else $error("disabled low byte read not live");

   a_hold_keep: assert property (
      @(posedge clk) disable iff (!rstn)
      !(rd && en && addr == TCC_A_CNT_HI) |=> $stable(r_ff.hold))
      else $error("held low byte changed without high read");
endmodule
`default_nettype wire

// ==== bench/tcc_pin_model.sv ====
// Far-side model: timer input source and GPIO output pin.
// Assumes the bench sets lvl after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_model (
   input wire logic clk,
   input wire logic lvl,
   input wire logic tmr_out,
   input wire logic tmr_out_oe,
   output logic tin,
   output logic pin
);
   logic last_ff = 1'b0;
   assign tin = lvl;
   always @(posedge clk) begin
      if (tmr_out_oe) begin
         last_ff <= tmr_out;
      end
   end
   // Undriven pin shows inverse of last driven level
   assign pin = tmr_out_oe ? tmr_out : ~last_ff;
endmodule
`default_nettype wire

// ==== bench/timer_capture_compare_readout_tb.sv ====
// Bench for the capture/compare timer with its pin model.
// Assumes tcc_pkg and tcc_timer are compiled first.
`timescale 1ns/10ps
`default_nettype none
module timer_capture_compare_readout_tb;
   import tcc_pkg::*;
   logic clk, rstn, wr, rd, lvl, tin, tmr_out, tmr_out_oe, irq, pin;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   tcc_timer i_dut (.clk(clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tin(tin),
      .tmr_out(tmr_out), .tmr_out_oe(tmr_out_oe), .irq(irq));
   tcc_pin_model i_pin (.clk(clk), .lvl(lvl), .tmr_out(tmr_out),
      .tmr_out_oe(tmr_out_oe), .tin(tin), .pin(pin));
   always #25 clk = ~clk;
   task automatic stop_test();
      if (n_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e,
         input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = {8'h00, rdata};
      @(posedge clk);
   endtask
   task automatic rd16(input logic [3:0] a, output logic [15:0] v);
      logic [15:0] h, l;
      rd_reg(a, h);
      rd_reg(a + 4'h1, l);
      v = {h[7:0], l[7:0]};
   endtask
   task automatic edge_to(input logic v);
      lvl <= v;
      repeat (6) @(posedge clk);
   endtask
   task automatic t_reset();
      logic [15:0] d;
      logic [7:0] e [10] = '{8'h00, 8'h01, 8'hff, 8'hff, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 10; i++) begin
         rd_reg(4'(i), d);
         chk("reset reg", {8'h00, e[i]}, d);
      end
      rd_reg(4'ha, d);
      chk("unmapped", 16'h0000, d);
      chk("irq", 16'h0000, 16'(irq));
   endtask
   task automatic t_capture();
      logic [15:0] v;
      wr_reg(TCC_A_CNT_HI, 8'h00);
      wr_reg(TCC_A_CNT_LO, 8'h01);
      wr_reg(TCC_A_RLD_HI, 8'hff);
      wr_reg(TCC_A_RLD_LO, 8'hff);
      wr_reg(TCC_A_MSK, 8'h03);
      wr_reg(TCC_A_CTL0, {6'h00, TCC_SEL_BOTH});
      edge_to(1'b1);
      edge_to(1'b0);
      wr_reg(TCC_A_CTL1, 8'hc2);
      repeat (20) @(posedge clk);
      rd16(TCC_A_CNT_HI, v);
      chk("idle count", 16'h0001, v);
      edge_to(1'b1);
      rd_reg(TCC_A_STS, v);
      chk("start sts", 16'h0000, v);
      edge_to(1'b0);
      repeat (386) @(posedge clk);
      rd_reg(TCC_A_STS, v);
      chk("fall sts", 16'h0000, v);
      edge_to(1'b1);
      rd16(TCC_A_CAP_HI, v);
      // 402 clocks at prescale 4 from start count 1
      chk("cap range", 16'h0001, 16'(v >= 16'h64 && v <= 16'h66));
      rd_reg(TCC_A_STS, v);
      chk("cap sts", 16'h0001, v);
      chk("cap irq", 16'h0001, 16'(irq));
      wr_reg(TCC_A_MSK, 8'h00);
      chk("masked irq", 16'h0000, 16'(irq));
      wr_reg(TCC_A_STS, 8'h01);
      rd_reg(TCC_A_STS, v);
      chk("cleared sts", 16'h0000, v);
   endtask
   task automatic t_reload();
      logic [15:0] v;
      logic prev;
      int tg;
      wr_reg(TCC_A_CTL1, 8'h00);
      wr_reg(TCC_A_CNT_LO, 8'h01);
      wr_reg(TCC_A_RLD_HI, 8'h00);
      wr_reg(TCC_A_RLD_LO, 8'h04);
      wr_reg(TCC_A_CTL0, {6'h20, TCC_SEL_CAP});
      wr_reg(TCC_A_MSK, 8'h03);
      wr_reg(TCC_A_CTL1, 8'hc0);
      edge_to(1'b0);
      edge_to(1'b1);
      chk("oe on", 16'h0001, 16'(tmr_out_oe));
      tg = 0;
      prev = pin;
      for (int i = 0; i < 40; i++) begin
         addr <= TCC_A_CNT_HI;
         rd <= (i % 4 == 0);
         @(negedge clk);
         tg += (pin !== prev);
         prev = pin;
         @(posedge clk);
      end
      // Four ticks per reload period at prescale 1
      chk("toggles", 16'h0001, 16'(tg >= 9 && tg <= 11));
      rd_reg(TCC_A_STS, v);
      chk("cap only", 16'h0000, v);
      wr_reg(TCC_A_CTL0, {6'h20, TCC_SEL_RLD});
      repeat (10) @(posedge clk);
      rd_reg(TCC_A_STS, v);
      chk("rld sts", 16'h0002, v);
      chk("rld irq", 16'h0001, 16'(irq));
      wr_reg(TCC_A_CTL0, 8'h00);
      @(negedge clk);
      chk("oe off", 16'h0000, 16'(tmr_out_oe));
      chk("out off", 16'h0000, 16'(tmr_out));
      @(posedge clk);
   endtask
   task automatic t_readout();
      logic [15:0] v, l1, l2;
      wr_reg(TCC_A_CTL1, 8'h00);
      wr_reg(TCC_A_RLD_HI, 8'hff);
      wr_reg(TCC_A_RLD_LO, 8'hff);
      wr_reg(TCC_A_CTL1, 8'hc0);
      edge_to(1'b0);
      edge_to(1'b1);
      rd16(TCC_A_CNT_HI, v);
      l1 = v;
      repeat (5) @(posedge clk);
      rd_reg(TCC_A_CNT_LO, l2);
      chk("held lo", {8'h00, l1[7:0]}, l2);
      rd16(TCC_A_CNT_HI, v);
      chk("new hold", 16'h0001, 16'(v[7:0] !== l1[7:0]));
      wr_reg(TCC_A_CTL1, 8'h00);
      wr_reg(TCC_A_CNT_LO, 8'h5a);
      rd_reg(TCC_A_CNT_LO, v);
      chk("live lo", 16'h005a, v);
   endtask
   task automatic t_falling();
      logic [15:0] v;
      wr_reg(TCC_A_STS, 8'h03);
      wr_reg(TCC_A_CNT_HI, 8'h00);
      wr_reg(TCC_A_CNT_LO, 8'h01);
      wr_reg(TCC_A_CTL0, {6'h00, TCC_SEL_RLD});
      wr_reg(TCC_A_CTL1, 8'h80);
      edge_to(1'b0);
      edge_to(1'b1);
      rd_reg(TCC_A_STS, v);
      chk("fall start sts", 16'h0000, v);
      edge_to(1'b0);
      rd_reg(TCC_A_STS, v);
      chk("rld only sts", 16'h0000, v);
      rd16(TCC_A_CAP_HI, v);
      // Falling edge 14 clocks after start, prescale 1
      chk("fall cap", 16'h000e, v);
      wr_reg(TCC_A_CTL0, 8'h03);
      edge_to(1'b1);
      edge_to(1'b0);
      rd_reg(TCC_A_STS, v);
      chk("both sts", 16'h0001, v);
      chk("both irq", 16'h0001, 16'(irq));
      wr_reg(TCC_A_CTL1, 8'h00);
   endtask
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      lvl = 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_capture();
      t_reload();
      t_readout();
      t_falling();
      stop_test();
   end
endmodule
`default_nettype wire
